// ==== common/baeu_cfg.svh ====
// Constants for the bit and arithmetic execution unit.
// Assumes an 8-bit data path and a 128-entry file register space.
`ifndef BAEU_CFG_SVH
`define BAEU_CFG_SVH
`define BAEU_DATA_W 8
`define BAEU_ADDR_W 7
`define BAEU_BIT_W 3
`define BAEU_NIB_W 4
`define BAEU_ACC_RST 8'h00
`define BAEU_DEST_ACC 1'b0
`define BAEU_DEST_FILE 1'b1
`endif

// ==== common/baeu_pkg.sv ====
// Types shared by the execution unit and its bench.
// Assumes the configuration header sits beside it.
`default_nettype none
package baeu_pkg;
    typedef enum logic [3:0] {
        no_op,
        add_literal_op,
        add_file_op,
        and_literal_op,
        and_file_op,
        bit_clear_op,
        bit_set_op,
        test_skip_if_clear_op,
        test_skip_if_set_op
    } baeu_op_type;
    typedef enum logic {
        baeu_st_idle,
        baeu_st_exec
    } baeu_state_type;
endpackage : baeu_pkg
`default_nettype wire

// ==== rtl/baeu_file_ram.sv ====
// File register storage: one write port, one read port.
// Read data come out of a register one clock after the read enable.
`default_nettype none
module baeu_file_ram #(
    parameter int DATA_W = 8,
    parameter int ADDR_W = 7
) (
    // Clock
    input wire logic i_clk,
    // Write side
    input wire logic i_wr_en,
    input wire logic [ADDR_W-1:0] i_wr_addr,
    input wire logic [DATA_W-1:0] i_wr_data,
    // Read side
    input wire logic i_rd_en,
    input wire logic [ADDR_W-1:0] i_rd_addr,
    output logic [DATA_W-1:0] o_rd_data
);
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    // Read before write on a shared address
    always_ff @(posedge i_clk) begin
        if (i_wr_en) begin
            mem[i_wr_addr] <= i_wr_data;
        end
        if (i_rd_en) begin
            o_rd_data <= mem[i_rd_addr];
        end
    end
endmodule : baeu_file_ram
`default_nettype wire

// ==== rtl/baeu_exec.sv ====
// Execution unit for add, and, bit set/clear and bit-test-skip operations.
// Latches the op at issue; the decoder may change the issue port while o_ready is low.
// Notes on behaviour
// - add_literal_op adds 8-bit literal to accumulator; updates carry, nibble, zero flags.
// - bit_clear_op zeroes chosen bit 0-7 of file register 0-127; flags untouched.
// - add_file_op sums accumulator and file register; updates carry, nibble, zero flags.
// - add_file_op and and_file_op send result to accumulator when dest is 0, file when 1.
// - bit_set_op sets chosen bit of the file register; flags untouched.
// - and_literal_op ANDs accumulator with literal; only zero flag changes.
// - and_file_op ANDs accumulator with file register to destination; only zero flag.
// - test_skip_if_clear_op discards next instruction when tested bit is zero.
// - test_skip_if_set_op discards next instruction when tested bit is one.
// - Taken skip costs a second cycle run as a no-op; tests alter no flag.
`default_nettype none
`include "baeu_cfg.svh"
module baeu_exec
    import baeu_pkg::*;
#(
    parameter int DATA_W = `BAEU_DATA_W,
    parameter int ADDR_W = `BAEU_ADDR_W
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // Issue port from the decoder
    input wire logic i_issue,
    input wire baeu_op_type i_op,
    input wire logic [DATA_W-1:0] i_literal,
    input wire logic [ADDR_W-1:0] i_faddr,
    input wire logic [`BAEU_BIT_W-1:0] i_bitsel,
    input wire logic i_dest,
    // File register load from the rest of the core
    input wire logic i_load_en,
    input wire logic [ADDR_W-1:0] i_load_addr,
    input wire logic [DATA_W-1:0] i_load_data,
    // Status
    output logic o_ready,
    output logic o_done,
    output logic o_discarded,
    output logic o_skip_pending,
    output logic [DATA_W-1:0] o_acc,
    output logic o_carry,
    output logic o_nibble_borrow_flag,
    output logic o_zero,
    // File register write report
    output logic o_wr_en,
    output logic [ADDR_W-1:0] o_wr_addr,
    output logic [DATA_W-1:0] o_wr_data
);
    ////////////////////////////////////////////////////////////////////////////
    // Reset release
    logic rst_meta, rst_n;
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    baeu_state_type state, next_state;
    logic ready, next_ready;
    baeu_op_type op_q, next_op_q;
    logic [DATA_W-1:0] lit_q, next_lit_q;
    logic [ADDR_W-1:0] addr_q, next_addr_q;
    logic [`BAEU_BIT_W-1:0] bit_q, next_bit_q;
    logic dest_q, next_dest_q;
    logic [DATA_W-1:0] acc, next_acc;
    logic carry, next_carry, nib, next_nib, zero, next_zero;
    logic skip, next_skip, done, next_done, discarded, next_discarded;
    logic wr_en, next_wr_en;
    logic [ADDR_W-1:0] wr_addr, next_wr_addr;
    logic [DATA_W-1:0] wr_data, next_wr_data;
    logic take, exec_live, ram_we, to_file, tbit;
    logic [ADDR_W-1:0] ram_waddr;
    logic [DATA_W-1:0] ram_wdata, fval, operand, result, mask;
    logic [DATA_W:0] sum;
    logic [`BAEU_NIB_W:0] nsum;

    ////////////////////////////////////////////////////////////////////////////
    // File storage; one clock to read, the second clock executes and writes
    baeu_file_ram #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) u_ram (
        .i_clk(i_clk),
        .i_wr_en(ram_we),
        .i_wr_addr(ram_waddr),
        .i_wr_data(ram_wdata),
        .i_rd_en(take),
        .i_rd_addr(i_faddr),
        .o_rd_data(fval)
    );
    ////////////////////////////////////////////////////////////////////////////
    // Datapath
    always_comb begin
        take = i_issue && ready && (state == baeu_st_idle);
        exec_live = (state == baeu_st_exec) && !skip;
        operand = (op_q == add_literal_op || op_q == and_literal_op) ? lit_q : fval;
        sum = {1'b0, acc} + {1'b0, operand};
        nsum = {1'b0, acc[`BAEU_NIB_W-1:0]} + {1'b0, operand[`BAEU_NIB_W-1:0]};
        mask = DATA_W'(1) << bit_q;
        tbit = |(fval & mask);
        result = acc;
        to_file = 1'b0;
        case (op_q)
            add_literal_op, add_file_op: begin
                result = sum[DATA_W-1:0];
                to_file = (op_q == add_file_op) && (dest_q == `BAEU_DEST_FILE);
            end
            and_literal_op, and_file_op: begin
                result = acc & operand;
                to_file = (op_q == and_file_op) && (dest_q == `BAEU_DEST_FILE);
            end
            bit_clear_op: begin
                result = fval & ~mask;
                to_file = 1'b1;
            end
            bit_set_op: begin
                result = fval | mask;
                to_file = 1'b1;
            end
            default: to_file = 1'b0;
        endcase
        // Load port only gets the memory while no op is executing
        ram_we = exec_live ? to_file : ((state == baeu_st_idle) && i_load_en);
        ram_waddr = exec_live ? addr_q : i_load_addr;
        ram_wdata = exec_live ? result : i_load_data;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Sequencing and architectural state
    always_comb begin
        next_state = state;
        next_ready = ready;
        next_op_q = op_q;
        next_lit_q = lit_q;
        next_addr_q = addr_q;
        next_bit_q = bit_q;
        next_dest_q = dest_q;
        next_acc = acc;
        next_carry = carry;
        next_nib = nib;
        next_zero = zero;
        next_skip = skip;
        next_done = 1'b0;
        next_discarded = 1'b0;
        next_wr_en = 1'b0;
        next_wr_addr = wr_addr;
        next_wr_data = wr_data;
        case (state)
            baeu_st_idle: begin
                next_ready = !take;
                if (take) begin
                    next_op_q = i_op;
                    next_lit_q = i_literal;
                    next_addr_q = i_faddr;
                    next_bit_q = i_bitsel;
                    next_dest_q = i_dest;
                    next_state = baeu_st_exec;
                end
            end
            baeu_st_exec: begin
                next_state = baeu_st_idle;
                next_ready = 1'b1;
                next_done = 1'b1;
                if (skip) begin
                    // Discarded slot runs as a no-op: nothing changes
                    next_skip = 1'b0;
                    next_discarded = 1'b1;
                end else begin
                    next_wr_en = to_file;
                    next_wr_addr = addr_q;
                    next_wr_data = result;
                    if (!to_file && op_q inside {add_literal_op, add_file_op,
                            and_literal_op, and_file_op}) begin
                        next_acc = result;
                    end
                    if (op_q == add_literal_op || op_q == add_file_op) begin
                        next_carry = sum[DATA_W];
                        next_nib = nsum[`BAEU_NIB_W];
                    end
                    if (op_q == add_literal_op || op_q == add_file_op
                            || op_q == and_literal_op || op_q == and_file_op) begin
                        next_zero = (result == '0);
                    end
                    if (op_q == test_skip_if_clear_op) begin
                        next_skip = !tbit;
                    end
                    if (op_q == test_skip_if_set_op) begin
                        next_skip = tbit;
                    end
                end
            end
            default: begin
                next_state = baeu_st_idle;
                next_ready = 1'b1;
            end
        endcase
    end
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= baeu_st_idle;
            ready <= 1'b0;
            op_q <= no_op;
            lit_q <= '0;
            addr_q <= '0;
            bit_q <= '0;
            dest_q <= 1'b0;
            acc <= `BAEU_ACC_RST;
            carry <= 1'b0;
            nib <= 1'b0;
            zero <= 1'b0;
            skip <= 1'b0;
            done <= 1'b0;
            discarded <= 1'b0;
            wr_en <= 1'b0;
            wr_addr <= '0;
            wr_data <= '0;
        end else begin
            state <= next_state;
            ready <= next_ready;
            op_q <= next_op_q;
            lit_q <= next_lit_q;
            addr_q <= next_addr_q;
            bit_q <= next_bit_q;
            dest_q <= next_dest_q;
            acc <= next_acc;
            carry <= next_carry;
            nib <= next_nib;
            zero <= next_zero;
            skip <= next_skip;
            done <= next_done;
            discarded <= next_discarded;
            wr_en <= next_wr_en;
            wr_addr <= next_wr_addr;
            wr_data <= next_wr_data;
        end
    end
    assign o_ready = ready;
    assign o_done = done;
    assign o_discarded = discarded;
    assign o_skip_pending = skip;
    assign o_acc = acc;
    assign o_carry = carry;
    assign o_nibble_borrow_flag = nib;
    assign o_zero = zero;
    assign o_wr_en = wr_en;
    assign o_wr_addr = wr_addr;
    assign o_wr_data = wr_data;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!rst_n);
    sequence s_test_taken;
        exec_live && ((op_q == test_skip_if_clear_op && !tbit)
            || (op_q == test_skip_if_set_op && tbit));
    endsequence
    sequence s_slot_dropped;
        skip && $stable(carry) && $stable(nib) && $stable(zero);
    endsequence
    a_add_lit_sum: assert property (exec_live && op_q == add_literal_op
        |=> acc == DATA_W'($past(acc) + $past(lit_q)) && carry == $past(sum[DATA_W]))
        else $error("literal add result wrong");
    a_add_file_flags: assert property (exec_live && op_q == add_file_op
        |=> nib == $past(nsum[`BAEU_NIB_W]) && zero == ($past(result) == '0))
        else $error("file add flags wrong");
    a_bit_clear: assert property (exec_live && op_q == bit_clear_op
        |=> wr_en && (wr_data & $past(mask)) == '0 && $stable(zero) && $stable(carry))
        else $error("bit clear failed");
    a_bit_set: assert property (exec_live && op_q == bit_set_op
        |=> wr_en && (wr_data & $past(mask)) != '0 && $stable(nib) && $stable(acc))
        else $error("bit set failed");
    a_dest_route: assert property (exec_live && (op_q == add_file_op || op_q == and_file_op)
        |=> wr_en == $past(dest_q) && ($past(dest_q) ? $stable(acc) : acc == wr_data))
        else $error("destination routing wrong");
    a_and_lit_flags: assert property (exec_live && op_q == and_literal_op
        |=> acc == ($past(acc) & $past(lit_q)) && $stable(carry) && $stable(nib))
        else $error("literal and wrong");
    a_and_file_zero: assert property (exec_live && op_q == and_file_op
        |=> zero == (($past(acc) & $past(fval)) == '0) && $stable(carry))
        else $error("file and zero flag wrong");
    a_skip_taken: assert property (s_test_taken |=> s_slot_dropped)
        else $error("skip not armed");
    a_skip_not: assert property (exec_live
        && (op_q == test_skip_if_clear_op || op_q == test_skip_if_set_op)
        && !((op_q == test_skip_if_clear_op) ? !tbit : tbit) |=> !skip && $stable(zero))
        else $error("skip armed wrongly");
    a_skip_nop: assert property (state == baeu_st_exec && skip
        |=> discarded && done && !wr_en && $stable(acc) && !skip)
        else $error("discarded slot had effect");
    a_one_cycle: assert property (take |=> !ready ##1 ready && done)
        else $error("op did not finish in one cycle");
endmodule : baeu_exec
`default_nettype wire

// ==== bench/baeu_tb.sv ====
// Self-checking bench for the bit and arithmetic execution unit.
// Assumes baeu_pkg is compiled first; the bench drives the issue and load ports itself.
`default_nettype none
module testbench import baeu_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic [7:0] acc; logic c; logic dc; logic z; logic skp; logic wr; logic disc;
        logic [6:0] a; logic [7:0] d; logic [31:0] due;
    } baeu_tb_exp_type;
    logic i_clk, i_resetn, i_issue, i_dest, i_load_en;
    baeu_op_type i_op;
    logic [7:0] i_literal, i_load_data;
    logic [6:0] i_faddr, i_load_addr;
    logic [2:0] i_bitsel;
    logic o_ready, o_done, o_discarded, o_skip_pending, o_carry, o_nibble_borrow_flag, o_zero;
    logic o_wr_en;
    logic [7:0] o_acc, o_wr_data;
    logic [6:0] o_wr_addr;
    logic [31:0] seed = 32'h1087;
    logic [31:0] cyc = 32'h0;
    int err_total = 0;
    int checks = 0;
    logic [7:0] mem [128];
    logic [7:0] m_acc;
    logic m_c, m_dc, m_z, m_skp;
    baeu_tb_exp_type q[$];
    baeu_exec dut_u (.i_clk(i_clk), .i_resetn(i_resetn), .i_issue(i_issue), .i_op(i_op),
        .i_literal(i_literal), .i_faddr(i_faddr), .i_bitsel(i_bitsel), .i_dest(i_dest),
        .i_load_en(i_load_en), .i_load_addr(i_load_addr), .i_load_data(i_load_data),
        .o_ready(o_ready), .o_done(o_done), .o_discarded(o_discarded),
        .o_skip_pending(o_skip_pending), .o_acc(o_acc), .o_carry(o_carry),
        .o_nibble_borrow_flag(o_nibble_borrow_flag), .o_zero(o_zero), .o_wr_en(o_wr_en),
        .o_wr_addr(o_wr_addr), .o_wr_data(o_wr_data));
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    // Returns {carry, low nibble carry, sum}
    function automatic logic [9:0] add_fn(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] s;
        logic [4:0] n;
        s = {1'b0, a} + {1'b0, b};
        n = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        return {s[8], n[4], s[7:0]};
    endfunction : add_fn
    task automatic finish_test();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    always @(posedge i_clk) begin
        cyc <= cyc + 32'h1;
        if (cyc == 32'd6000) begin
            err_total++;
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wait_ready();
        while (o_ready !== 1'b1) begin
            @(posedge i_clk);
            #2;
        end
    endtask : wait_ready
    // Load strobe stays up across back-to-back loads; the next issue lowers it
    task automatic load(input logic [6:0] a, input logic [7:0] d);
        wait_ready();
        i_issue = 1'b0;
        i_load_en = 1'b1;
        i_load_addr = a;
        i_load_data = d;
        @(posedge i_clk);
        #2;
        mem[a] = d;
    endtask : load
    // Model runs at the take edge, in issue order, so the queue matches o_done order
    task automatic model(input baeu_op_type op, input logic [7:0] k, input logic [6:0] a,
                         input logic [2:0] b, input logic d);
        baeu_tb_exp_type e;
        logic [9:0] r;
        logic [7:0] v;
        e.wr = 1'b0;
        e.disc = m_skp;
        e.a = a;
        e.due = cyc + 32'd1;
        v = mem[a];
        r = add_fn(m_acc, (op == add_literal_op) ? k : v);
        if (m_skp) begin
            m_skp = 1'b0;
        end else begin
            case (op)
                add_literal_op: {m_c, m_dc, m_acc} = r;
                add_file_op: {m_c, m_dc, v} = r;
                and_literal_op: m_acc = m_acc & k;
                and_file_op: v = m_acc & v;
                bit_clear_op: v[b] = 1'b0;
                bit_set_op: v[b] = 1'b1;
                test_skip_if_clear_op: m_skp = (v[b] == 1'b0);
                test_skip_if_set_op: m_skp = (v[b] == 1'b1);
                default: ;
            endcase
            if (op inside {add_literal_op, and_literal_op}) m_z = (m_acc == 8'h00);
            if (op inside {add_file_op, and_file_op}) m_z = (v == 8'h00);
            if (op inside {add_file_op, and_file_op} && d == 1'b0) begin
                m_acc = v;
            end else if (op inside {add_file_op, and_file_op, bit_clear_op, bit_set_op}) begin
                mem[a] = v;
                e.wr = 1'b1;
            end
        end
        e.d = v;
        {e.acc, e.c, e.dc, e.z, e.skp} = {m_acc, m_c, m_dc, m_z, m_skp};
        q.push_back(e);
    endtask : model
    task automatic issue(input baeu_op_type op, input logic [7:0] k, input logic [6:0] a,
                         input logic [2:0] b, input logic d);
        wait_ready();
        i_load_en = 1'b0;
        {i_op, i_literal, i_faddr, i_bitsel, i_dest} = {op, k, a, b, d};
        i_issue = 1'b1;
        @(posedge i_clk);
        #2;
        model(op, k, a, b, d);
        // Junk held on the port while busy must be ignored; the request stays up
        // so a following call issues back to back, and the caller lowers it
        i_op = baeu_op_type'(rnd() % 9);
        i_literal = 8'(rnd());
        @(posedge i_clk);
        #2;
    endtask : issue
    always @(posedge i_clk) begin
        #1;
        if (i_resetn === 1'b1 && o_done === 1'b1) begin
            if (q.size() == 0) begin
                chk(16'h1, 16'h0);
            end else begin
                baeu_tb_exp_type e;
                e = q.pop_front();
                chk(cyc[15:0], e.due[15:0]);
                chk(o_ready, 1'b1);
                chk(o_discarded, e.disc);
                chk(o_skip_pending, e.skp);
                chk(o_acc, e.acc);
                chk({o_carry, o_nibble_borrow_flag, o_zero}, {e.c, e.dc, e.z});
                chk(o_wr_en, e.wr);
                if (e.wr) chk({o_wr_addr, o_wr_data}, {1'b0, e.a, e.d});
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {i_issue, i_dest, i_load_en, i_literal, i_load_data, i_faddr, i_load_addr} = '0;
        i_op = no_op;
        i_bitsel = 3'h0;
        {m_acc, m_c, m_dc, m_z, m_skp} = '0;
        i_resetn = 1'b0;
        repeat (4) @(posedge i_clk);
        #2;
        chk({o_ready, o_acc}, 9'h000);
        i_resetn = 1'b1;
        for (int a = 0; a < 128; a++) load(a[6:0], 8'(rnd()));
        // Flag boundaries: zero, nibble carry, carry with zero result
        issue(and_literal_op, 8'h00, 7'h00, 3'h0, 1'b0);
        issue(add_literal_op, 8'h0f, 7'h00, 3'h0, 1'b0);
        issue(add_literal_op, 8'h01, 7'h00, 3'h0, 1'b0);
        issue(add_literal_op, 8'hf0, 7'h00, 3'h0, 1'b0);
        issue(add_literal_op, 8'hff, 7'h00, 3'h0, 1'b0);
        // Skip not taken, taken, then a skip that is itself discarded
        load(7'h7f, 8'h01);
        issue(test_skip_if_clear_op, 8'h00, 7'h7f, 3'h0, 1'b0);
        issue(test_skip_if_set_op, 8'h00, 7'h7f, 3'h0, 1'b0);
        issue(test_skip_if_set_op, 8'h00, 7'h7f, 3'h0, 1'b0);
        issue(test_skip_if_clear_op, 8'h00, 7'h7f, 3'h7, 1'b0);
        issue(add_file_op, 8'h00, 7'h7f, 3'h0, 1'b1);
        for (int n = 0; n < 500; n++) begin
            if (rnd() % 8 == 0) load(7'(rnd()), 8'(rnd()));
            issue(baeu_op_type'(rnd() % 9), 8'(rnd()), (rnd() % 4 == 0) ? 7'h7f : 7'(rnd()),
                  3'(rnd()), 1'(rnd()));
        end
        i_issue = 1'b0;
        repeat (4) @(posedge i_clk);
        chk(16'(q.size()), 16'h0);
        // Reset in mid-run clears accumulator, flags and pending skip
        #2;
        i_resetn = 1'b0;
        #2;
        chk({o_ready, o_done, o_skip_pending, o_acc, o_carry, o_nibble_borrow_flag, o_zero}, 16'h0);
        {m_acc, m_c, m_dc, m_z, m_skp} = '0;
        repeat (4) @(posedge i_clk);
        #2;
        i_resetn = 1'b1;
        issue(add_literal_op, 8'h80, 7'h00, 3'h0, 1'b0);
        i_issue = 1'b0;
        repeat (4) @(posedge i_clk);
        chk(16'(q.size()), 16'h0);
        finish_test();
    end
endmodule : testbench
`default_nettype wire
